//--- hdl/reset_cause_pkg.sv
// Purpose: Constants and types for the reset-cause flag block
// Assumes: Classic Wishbone slave with 32-bit data, one system clock
// Notes:   Bit positions follow the reset cause control word layout
//
// Behaviour
// - Each cause flag sets on its event; brown-out flag also sets on power-on.
// - Power-on clears cause flags except power-on and brown-out; power-save instruction also clears watchdog flag.
// - Software sets and clears every flag; setting never starts a reset.
// - Unprogrammed watchdog fuse keeps the watchdog enabled regardless of software.
// - Programmed fuse: software watchdog bit enables (1) or disables (0) it.
// - Clock switching off: reset clock source always from fuse oscillator bits.
// - Clock switching on: reset clock source depends on the reset type.
// - Power-on and brown-out take fuse field; pin, watchdog, software keep current.

package reset_cause_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0]  ADDR_RESET_CAUSE_CONTROL = 8'h00;
  localparam logic [7:0]  ADDR_CLOCK_STATUS        = 8'h04;
  localparam int          REG_WIDTH                = 16;

  // Field positions in the reset cause control word
  localparam int BIT_TRAP_CONFLICT   = 15;
  localparam int BIT_ILLEGAL_ACCESS  = 14;
  localparam int BIT_PIN_RESET       = 7;
  localparam int BIT_INSTR_RESET     = 6;
  localparam int BIT_SOFT_WATCHDOG   = 5;
  localparam int BIT_WATCHDOG_EXPIRY = 4;
  localparam int BIT_SLEEP           = 3;
  localparam int BIT_IDLE            = 2;
  localparam int BIT_BROWNOUT        = 1;
  localparam int BIT_POWER_ON        = 0;

  // Implemented bits; the rest read as zero
  localparam logic [15:0] IMPL_MASK  = 16'hc0ff;
  // Value after power-on: brown-out and power-on flags set
  localparam logic [15:0] RESET_VALUE = 16'h0003;

  // Clock source field width and its position in the status word
  localparam int          OSC_WIDTH     = 3;
  localparam int          BIT_CLK_SRC   = 0;
  localparam int          BIT_WDT_EN    = 4;

  // ==========================================================================
  // Types
  // ==========================================================================
  // One-cycle event pulses from the core and reset sources
  typedef struct packed {
    logic trap_conflict;
    logic illegal_access;
    logic pin_reset;
    logic instr_reset;
    logic watchdog_timeout;
    logic sleep_entry;
    logic idle_entry;
    logic brownout;
    logic power_save_instruction;
  } reset_events_t;

  // Static configuration straps and oscillator state
  typedef struct packed {
    logic                 watchdog_fuse_enable;
    logic                 clock_switch_enable;
    logic [OSC_WIDTH-1:0] fuse_oscillator_select;
    logic [OSC_WIDTH-1:0] current_oscillator_field;
  } clock_config_t;

endpackage

//--- hdl/flag_cell.sv
// Purpose: One sticky flag bit with hardware set, hardware clear and write
// Assumes: Synchronous active-low power-on reset
// Notes:   Hardware set wins over any clear in the same cycle

`timescale 1ns/1ps
`default_nettype none

module flag_cell #(
  parameter logic RESET_BIT = 1'b0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  input  wire logic i_write,
  input  wire logic i_wdata,
  output logic      o_flag
);

  // ==========================================================================
  // Flag storage
  // ==========================================================================
  // Priority: power-on, hardware set, software write, hardware clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_flag <= RESET_BIT;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_write) begin
      o_flag <= i_wdata;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

endmodule // flag_cell

`default_nettype wire

//--- hdl/reset_cause_flags.sv
// Purpose: Reset-cause flags, watchdog enable gating and reset clock choice
// Assumes: i_reset_n is the power-on reset; other resets arrive as pulses
// Notes:   Registers reached over a classic Wishbone slave, one-wait ack
//          Resets other than power-on never clear a flag; each flag cell
//          lets a hardware set win over a software write in the same cycle
//
// Implementation choices: the register offsets and the Wishbone slave port.

`timescale 1ns/1ps
`default_nettype none

module reset_cause_flags (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_reset_n,
  // Wishbone slave
  input  wire logic                          i_wb_cyc,
  input  wire logic                          i_wb_stb,
  input  wire logic                          i_wb_we,
  input  wire logic [7:0]                    i_wb_adr,
  input  wire logic [3:0]                    i_wb_sel,
  input  wire logic [31:0]                   i_wb_dat,
  output logic      [31:0]                   o_wb_dat,
  output logic                               o_wb_ack,
  // Event pulses and configuration
  input  wire reset_cause_pkg::reset_events_t i_events,
  input  wire reset_cause_pkg::clock_config_t i_config,
  // Results
  output logic                               o_watchdog_enable,
  output logic [reset_cause_pkg::OSC_WIDTH-1:0] o_clock_source
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic                                  ack;
  logic                                  req;
  logic                                  take;
  logic                                  hit_control;
  logic                                  hit_status;
  logic                                  write_commit;
  logic [15:0]                           write_lane;
  logic [15:0]                           flags;
  logic [15:0]                           set_vec;
  logic [15:0]                           clear_vec;
  logic [31:0]                           status_word;
  logic [31:0]                           next_rdata;
  logic                                  device_reset_keep;
  logic                                  ack_first_pending;
  logic                                  next_watchdog_enable;
  logic [reset_cause_pkg::OSC_WIDTH-1:0] next_clock_source;

  // Address match against the two words of the map
  // Anything else is still acked and reads zero, so software never hangs
  always_comb begin
    hit_control = 1'b0;
    hit_status  = 1'b0;
    if (i_wb_adr == reset_cause_pkg::ADDR_RESET_CAUSE_CONTROL) begin
      hit_control = 1'b1;
    end else if (i_wb_adr == reset_cause_pkg::ADDR_CLOCK_STATUS) begin
      hit_status = 1'b1;
    end
  end

  // A request is live while cycle and strobe are both high
  assign req  = i_wb_cyc & i_wb_stb;

  // Taken on the edge that sees the request with ack low; the ack edge of
  // a held request is not a second take
  assign take = req & ~ack;

  // Write takes effect on the edge that samples ack high, so a master that
  // holds its request through the wait state commits exactly once
  assign write_commit = req & i_wb_we & ack & hit_control;

  // Byte enables gate the two low lanes of the 16-bit word
  assign write_lane = {{8{write_commit & i_wb_sel[1]}}, {8{write_commit & i_wb_sel[0]}}};

  // Ack one cycle after the take, dropped the cycle after even if the
  // master keeps its strobe up
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= take;
    end
  end

  // Ack leaves straight from its flop
  assign o_wb_ack = ack;

  // Status word: current watchdog enable and chosen clock source
  // Bits 2:0 carry the clock source and bit 4 the watchdog enable
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[reset_cause_pkg::BIT_CLK_SRC +: reset_cause_pkg::OSC_WIDTH] = o_clock_source;
    status_word[reset_cause_pkg::BIT_WDT_EN] = o_watchdog_enable;
  end

  // Read mux; unmapped words give zero
  // The status word and unmapped words simply ignore writes
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_control) begin
      next_rdata = {16'h0000, flags};
    end else if (hit_status) begin
      next_rdata = status_word;
    end
  end

  // Read data captured at the take, so it is valid in the ack cycle and held until the next take
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (take) begin
      o_wb_dat <= next_rdata;
    end
  end

  // ==========================================================================
  // Flag events
  // ==========================================================================
  // Hardware set and clear sources per bit position
  // A clear only matters when no set or write lands in the same cycle
  always_comb begin
    set_vec   = 16'h0000;
    clear_vec = 16'h0000;
    set_vec[reset_cause_pkg::BIT_TRAP_CONFLICT]   = i_events.trap_conflict;
    set_vec[reset_cause_pkg::BIT_ILLEGAL_ACCESS]  = i_events.illegal_access;
    set_vec[reset_cause_pkg::BIT_PIN_RESET]       = i_events.pin_reset;
    set_vec[reset_cause_pkg::BIT_INSTR_RESET]     = i_events.instr_reset;
    set_vec[reset_cause_pkg::BIT_WATCHDOG_EXPIRY] = i_events.watchdog_timeout;
    set_vec[reset_cause_pkg::BIT_SLEEP]           = i_events.sleep_entry;
    set_vec[reset_cause_pkg::BIT_IDLE]            = i_events.idle_entry;
    set_vec[reset_cause_pkg::BIT_BROWNOUT]        = i_events.brownout;
    // Power-save instruction clears the watchdog expiry flag
    clear_vec[reset_cause_pkg::BIT_WATCHDOG_EXPIRY] = i_events.power_save_instruction;
  end

  // One sticky cell per implemented bit; others read zero.
  // The power-on flag has no event input: only its reset value or a software write sets it,
  // and bits 13 to 8 are left out, so software sees zeros there
  for (genvar b = 0; b < reset_cause_pkg::REG_WIDTH; b++) begin : g_flag
    if (reset_cause_pkg::IMPL_MASK[b]) begin : g_impl
      flag_cell #(
        .RESET_BIT (reset_cause_pkg::RESET_VALUE[b])
      ) u_flag (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_set     (set_vec[b]),
        .i_clear   (clear_vec[b]),
        .i_write   (write_lane[b]),
        .i_wdata   (i_wb_dat[b]),
        .o_flag    (flags[b])
      );
    end else begin : g_none
      assign flags[b] = 1'b0;
    end
  end

  // ==========================================================================
  // Watchdog enable
  // ==========================================================================
  // Unprogrammed fuse forces enable, else the software bit decides
  always_comb begin
    if (i_config.watchdog_fuse_enable) begin
      next_watchdog_enable = 1'b1;
    end else begin
      next_watchdog_enable = flags[reset_cause_pkg::BIT_SOFT_WATCHDOG];
    end
  end

  // Registered so the pin and the status word agree; one cycle behind the
  // fuse and the software bit, and low while power-on reset is held
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_watchdog_enable <= 1'b0;
    end else begin
      o_watchdog_enable <= next_watchdog_enable;
    end
  end

  // ==========================================================================
  // Clock source at reset
  // ==========================================================================
  // Resets that keep the current oscillator when switching is enabled;
  // trap and illegal-access resets go with the pin and software resets
  assign device_reset_keep = i_events.pin_reset | i_events.watchdog_timeout
                           | i_events.instr_reset | i_events.trap_conflict
                           | i_events.illegal_access;

  // Marks the first active edge after power-on, which brings no event pulse,
  // so that the fuse oscillator field is loaded there
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ack_first_pending <= 1'b1;
    end else begin
      ack_first_pending <= 1'b0;
    end
  end

  // Next clock source: power-on and brown-out take the fuse field, other
  // resets follow the switching strap, and between resets the choice holds.
  // A brown-out that meets a pin reset in one cycle still takes the fuse
  always_comb begin
    next_clock_source = o_clock_source;
    if (ack_first_pending) begin
      next_clock_source = i_config.fuse_oscillator_select;
    end else if (i_events.brownout) begin
      next_clock_source = i_config.fuse_oscillator_select;
    end else if (device_reset_keep) begin
      if (i_config.clock_switch_enable) begin
        next_clock_source = i_config.current_oscillator_field;
      end else begin
        next_clock_source = i_config.fuse_oscillator_select;
      end
    end
  end

  // Clock source register; zero only while power-on reset is held
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_clock_source <= '0;
    end else begin
      o_clock_source <= next_clock_source;
    end
  end

endmodule // reset_cause_flags

`default_nettype wire

//--- verif/core_event_model.sv
// Purpose: Core-side model that fires one-cycle reset event pulses
// Assumes: Pulses start just after a rising edge
// Notes:   Index follows the event struct, power-save at 0
`timescale 1ns/1ps
`default_nettype none
module core_event_model (
  input  wire logic                         i_clk_sys,
  output var reset_cause_pkg::reset_events_t o_events
);
  // Quiet between pulses; each pulse lasts exactly one cycle
  initial o_events = '0;
  task automatic fire(input int idx);
    @(posedge i_clk_sys);
    o_events <= reset_cause_pkg::reset_events_t'(9'h001 << idx);
    @(posedge i_clk_sys);
    o_events <= '0;
  endtask
endmodule // core_event_model
`default_nettype wire

//--- verif/reset_cause_flags_assertions.sv
// Purpose: Port-level checks for the reset-cause flag block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags_assertions (
  input wire logic                           i_clk_sys,
  input wire logic                           i_reset_n,
  input wire logic                           i_wb_cyc,
  input wire logic                           i_wb_stb,
  input wire logic                           i_wb_we,
  input wire logic [7:0]                     i_wb_adr,
  input wire logic [31:0]                    o_wb_dat,
  input wire logic                           o_wb_ack,
  input wire reset_cause_pkg::reset_events_t i_events,
  input wire reset_cause_pkg::clock_config_t i_config,
  input wire logic                           o_watchdog_enable,
  input wire logic [2:0]                     o_clock_source
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================================
  // Bus and flag checks
  // ==========================================================================
  property p_ack_once;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one cycle");
  property p_unmapped_zero;
    o_wb_ack && !i_wb_we && i_wb_adr != 8'h00 && i_wb_adr != 8'h04 |-> o_wb_dat == 0; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
  property p_flag_seen;
    i_events.pin_reset ##2 (i_wb_cyc && i_wb_stb && !i_wb_we && i_wb_adr == 8'h00)
    |=> o_wb_dat[7]; endproperty
  a_flag_seen: assert property (p_flag_seen) else $error("pin flag lost");
  // ==========================================================================
  // Watchdog and clock source checks
  // ==========================================================================
  property p_wdog_fuse;
    i_config.watchdog_fuse_enable [*3] |-> o_watchdog_enable; endproperty
  a_wdog_fuse: assert property (p_wdog_fuse) else $error("watchdog off");
  property p_por_src;
    $rose(i_reset_n) |=> o_clock_source == $past(i_config.fuse_oscillator_select); endproperty
  a_por_src: assert property (p_por_src) else $error("power-on source");
  property p_brown_src;
    i_events.brownout |=> o_clock_source == $past(i_config.fuse_oscillator_select); endproperty
  a_brown_src: assert property (p_brown_src) else $error("brown-out source");
  property p_pin_keep;
    i_events.pin_reset && i_config.clock_switch_enable && !i_events.brownout
    |=> o_clock_source == $past(i_config.current_oscillator_field); endproperty
  a_pin_keep: assert property (p_pin_keep) else $error("pin source kept");
  property p_pin_fuse;
    i_events.pin_reset && !i_config.clock_switch_enable
    |=> o_clock_source == $past(i_config.fuse_oscillator_select); endproperty
  a_pin_fuse: assert property (p_pin_fuse) else $error("pin source fuse");
endmodule // reset_cause_flags_assertions
`default_nettype wire

//--- verif/tb.sv
// Purpose: Self-checking bench for the reset-cause flag block
// Assumes: Wishbone answers one cycle after the request is taken
// Notes:   Event pulses come from the core model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                           clk = 1'b0;
  logic                           rst_n, cyc, stb, we, ack, wd;
  logic [7:0]                     adr;
  logic [3:0]                     sel;
  logic [31:0]                    wdat, rdat, q, exp;
  logic [2:0]                     clk_src;
  reset_cause_pkg::clock_config_t cfg;
  reset_cause_pkg::reset_events_t events;
  int                             errors, checks;
  always #4 clk = ~clk;
  reset_cause_flags DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_events(events), .i_config(cfg), .o_watchdog_enable(wd),
    .o_clock_source(clk_src));
  core_event_model model (.i_clk_sys(clk), .o_events(events));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h3, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_por();
    rd(8'h00, "control", 32'h0003);
    rd(8'h04, "status", 32'h0012);
    rd(8'h10, "unmapped", 32'h0);
  endtask
  task automatic t_events();
    int bits[8] = '{15, 14, 7, 6, 4, 3, 2, 1};
    wb(1'b1, 8'h00, 32'h0);
    exp = 32'h0;
    for (int i = 0; i < 8; i++) begin
      model.fire(8 - i);
      exp[bits[i]] = 1'b1;
      rd(8'h00, "flags", exp);
    end
    model.fire(0);
    exp[4] = 1'b0;
    rd(8'h00, "wdog clear", exp);
    wb(1'b1, 8'h00, 32'hffffffff);
    rd(8'h00, "sw set", 32'hc0ff);
  endtask
  task automatic t_wdog();
    cfg.watchdog_fuse_enable <= 1'b0;
    rd(8'h04, "soft on", 32'h0012);
    chk("wdog pin", 32'h1, {31'h0, wd});
    wb(1'b1, 8'h00, 32'h0);
    rd(8'h04, "soft off", 32'h0002);
    chk("wdog pin", 32'h0, {31'h0, wd});
    cfg.watchdog_fuse_enable <= 1'b1;
    rd(8'h04, "fuse on", 32'h0012);
    chk("wdog pin", 32'h1, {31'h0, wd});
  endtask
  task automatic t_clock();
    cfg.clock_switch_enable <= 1'b1;
    model.fire(6);
    rd(8'h04, "pin keep", 32'h0015);
    chk("source pin", 32'h5, {29'h0, clk_src});
    model.fire(1);
    rd(8'h04, "brown fuse", 32'h0012);
    cfg <= {2'b10, 3'h6, 3'h5};
    model.fire(6);
    rd(8'h04, "fuse only", 32'h0016);
    wb(1'b1, 8'h04, 32'h0);
    rd(8'h04, "read only", 32'h0016);
    cfg.fuse_oscillator_select <= 3'h3;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, "power on", 32'h0003);
    rd(8'h04, "power on source", 32'h0013);
    chk("source pin", 32'h3, {29'h0, clk_src});
  endtask
  initial begin
    {rst_n, cyc, stb, we, adr, sel, wdat} = '0;
    cfg = {2'b10, 3'h2, 3'h5};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_por();
    t_events();
    t_wdog();
    t_clock();
    tally_and_finish();
  end
endmodule // tb
bind reset_cause_flags reset_cause_flags_assertions chk_u (.i_clk_sys(i_clk_sys),
  .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_events(i_events),
  .i_config(i_config), .o_watchdog_enable(o_watchdog_enable),
  .o_clock_source(o_clock_source));
`default_nettype wire
